// >>> logic/uart_buffer_regs.sv
// uart receive/transmit buffers, baud divisor and mode parameter registers behind apb
// assumes receiver pushes bytes on CLOCK, transmit shifter pops with TX_READY; depths are powers of two
//
// The APB interface to the registers was left to the implementer.

module uart_buffer_regs #(
   parameter int RX_DEPTH = 2,
   parameter int TX_DEPTH = 2,
   parameter bit LIMITED  = 1'b0
) (
   input  wire logic                            CLOCK,
   input  wire logic                            RST_N,
   input  wire logic                            CE,
   input  wire logic                            PSEL,
   input  wire logic                            PENABLE,
   input  wire logic                            PWRITE,
   input  wire logic [uart_regs_pkg::APB_AW-1:0] PADDR,
   input  wire logic [31:0]                     PWDATA,
   output wire logic [31:0]                     PRDATA,
   output wire logic                            PREADY,
   output wire logic                            PSLVERR,
   input  wire logic                            RX_VALID,
   input  wire logic [7:0]                      RX_DATA,
   input  wire logic                            TX_READY,
   output wire logic                            TX_VALID,
   output wire logic [7:0]                      TX_DATA,
   output wire logic                            TX_FLUSH,
   output wire logic                            BAUD_TICK,
   output wire logic [8:0]                      PARAM_ONE,
   output wire logic [8:0]                      PARAM_TWO,
   output wire logic [5:0]                      LIN_PID,
   output wire logic [7:0]                      LIN_TX_COUNT,
   output wire logic [8:0]                      ADDR_CHAR,
   output wire logic                            ADDR_MATCH
);
   import uart_regs_pkg::*;

   localparam int RPW = $clog2(RX_DEPTH);
   localparam int TPW = $clog2(TX_DEPTH);
   localparam int RCW = $clog2(RX_DEPTH + 1);
   localparam int TCW = $clog2(TX_DEPTH + 1);
   localparam logic [RCW-1:0] RX_FULL_CNT = RCW'(RX_DEPTH);
   localparam logic [TCW-1:0] TX_FULL_CNT = TCW'(TX_DEPTH);

   typedef struct packed {
      logic [RX_DEPTH-1:0][7:0] rx_mem;
      logic [RPW-1:0]           rx_rd;
      logic [RPW-1:0]           rx_wr;
      logic [RCW-1:0]           rx_cnt;
      logic [TX_DEPTH-1:0][7:0] tx_mem;
      logic [TPW-1:0]           tx_rd;
      logic [TPW-1:0]           tx_wr;
      logic [TCW-1:0]           tx_cnt;
      logic [7:0]               transmit_data_port;
      logic [15:0]              baud_divisor_value;
      logic [8:0]               p1;
      logic [8:0]               p2;
      logic [7:0]               mask;
      logic [7:0]               ctrl;
      logic [15:0]              bcnt;
      logic [31:0]              prdata;
      logic                     pready;
      logic                     pslverr;
      logic                     tx_valid;
      logic [7:0]               tx_data;
      logic                     tx_flush;
      logic                     tick;
      logic [8:0]               par1;
      logic [8:0]               par2;
      logic [5:0]               protected_identifier;
      logic [7:0]               lin_cnt;
      logic [8:0]               achar;
      logic                     match;
   } state_s;

   state_s s_q;
   state_s s_d;

   function automatic logic hit(input logic [APB_AW-1:0] a, input logic [11:0] idx);
      return (a[1:0] == 2'b00) && (a[APB_AW-1:2] == idx);
   endfunction

   function automatic logic ninth_used(input logic [3:0] m);
      return !LIMITED && (m == MODE_DMX || m == MODE_DGEAR || m == MODE_DDEV);
   endfunction

   logic        setup;
   logic        wr;
   logic        rd;
   logic        rx_flush;
   logic        rx_pop;
   logic        rx_push;
   logic        tx_flush;
   logic        tx_push;
   logic        tx_pop;
   logic [16:0] step;
   logic [16:0] bsum;
   logic [7:0]  rx_head;

   assign setup   = PSEL && !PENABLE;
   assign wr      = PSEL && PENABLE && s_q.pready && PWRITE;
   assign rd      = PSEL && PENABLE && s_q.pready && !PWRITE;
   assign rx_head = s_q.rx_mem[s_q.rx_rd];

   always_comb begin
      s_d          = s_q;
      s_d.tx_flush = 1'b0;
      s_d.tick     = 1'b0;
      rx_flush     = wr && hit(PADDR, IDX_STAT) && PWDATA[ST_RECEIVE_EMPTY_FLAG];
      tx_flush     = wr && hit(PADDR, IDX_STAT) && PWDATA[ST_TRANSMIT_EMPTY_FLAG];
      rx_pop       = rd && hit(PADDR, IDX_RXB) && (s_q.rx_cnt != '0);
      // a byte arriving during a flush or a pop is kept, not lost
      rx_push      = RX_VALID && ((s_q.rx_cnt != RX_FULL_CNT) || rx_pop || rx_flush);
      tx_pop       = s_q.tx_valid && TX_READY && !tx_flush;
      tx_push      = wr && hit(PADDR, IDX_TXB) && ((s_q.tx_cnt != TX_FULL_CNT) || tx_pop);
      step         = s_q.ctrl[CT_BAUD_SPEED_SELECT] ? STEP_FAST : STEP_NORM;
      bsum         = {1'b0, s_q.bcnt} + step;

      // apb: answer is prepared in setup, presented in the first access cycle
      s_d.pready  = setup;
      s_d.pslverr = 1'b0;
      s_d.prdata  = 32'h0000_0000;
      if (setup) begin
         if (hit(PADDR, IDX_RXB)) begin
            s_d.prdata[7:0] = rx_head;
         end else if (hit(PADDR, IDX_TXB)) begin
            s_d.prdata[7:0] = s_q.transmit_data_port;
         end else if (hit(PADDR, IDX_P1L)) begin
            s_d.prdata[7:0] = s_q.p1[7:0];
         end else if (hit(PADDR, IDX_P1H)) begin
            s_d.prdata[0] = s_q.p1[8];
         end else if (hit(PADDR, IDX_P2L)) begin
            s_d.prdata[7:0] = s_q.p2[7:0];
         end else if (hit(PADDR, IDX_P2H)) begin
            s_d.prdata[0] = s_q.p2[8];
         end else if (hit(PADDR, IDX_MASK)) begin
            s_d.prdata[7:0] = s_q.mask;
         end else if (hit(PADDR, IDX_CTRL)) begin
            s_d.prdata[7:0] = s_q.ctrl;
         end else if (hit(PADDR, IDX_BRGL)) begin
            s_d.prdata[7:0] = s_q.baud_divisor_value[7:0];
         end else if (hit(PADDR, IDX_BRGH)) begin
            s_d.prdata[7:0] = s_q.baud_divisor_value[15:8];
         end else if (hit(PADDR, IDX_STAT)) begin
            s_d.prdata[ST_TRANSMIT_EMPTY_FLAG] = (s_q.tx_cnt == '0);
            s_d.prdata[ST_TXBF] = (s_q.tx_cnt == TX_FULL_CNT);
            s_d.prdata[ST_RECEIVE_EMPTY_FLAG] = (s_q.rx_cnt == '0);
            s_d.prdata[ST_RECEIVE_FULL_FLAG] = (s_q.rx_cnt == RX_FULL_CNT);
         end else begin
            s_d.pslverr = 1'b1;
         end
      end

      // register writes; zeros written to the status flags do nothing
      if (wr && hit(PADDR, IDX_TXB)) begin
         s_d.transmit_data_port = PWDATA[7:0];
      end else if (wr && hit(PADDR, IDX_P1L)) begin
         s_d.p1[7:0] = PWDATA[7:0];
      end else if (wr && hit(PADDR, IDX_P1H)) begin
         s_d.p1[8] = PWDATA[0];
      end else if (wr && hit(PADDR, IDX_P2L)) begin
         s_d.p2[7:0] = PWDATA[7:0];
      end else if (wr && hit(PADDR, IDX_P2H)) begin
         s_d.p2[8] = PWDATA[0];
      end else if (wr && hit(PADDR, IDX_MASK)) begin
         s_d.mask = PWDATA[7:0];
      end else if (wr && hit(PADDR, IDX_CTRL)) begin
         s_d.ctrl = PWDATA[7:0];
      end else if (wr && hit(PADDR, IDX_BRGL) && !s_q.ctrl[CT_ON]) begin
         s_d.baud_divisor_value[7:0] = PWDATA[7:0];
      end else if (wr && hit(PADDR, IDX_BRGH) && !s_q.ctrl[CT_ON]) begin
         s_d.baud_divisor_value[15:8] = PWDATA[7:0];
      end

      // receive fifo
      if (rx_flush) begin
         s_d.rx_rd  = '0;
         s_d.rx_wr  = '0;
         s_d.rx_cnt = '0;
      end else if (rx_pop) begin
         s_d.rx_rd  = s_q.rx_rd + 1'b1;
         s_d.rx_cnt = s_q.rx_cnt - 1'b1;
      end
      if (rx_push) begin
         s_d.rx_mem[s_d.rx_wr] = RX_DATA;
         s_d.rx_wr             = s_d.rx_wr + 1'b1;
         s_d.rx_cnt            = s_d.rx_cnt + 1'b1;
      end

      // transmit fifo; a flush also tells the shifter to drop its byte
      if (tx_flush) begin
         s_d.tx_rd    = '0;
         s_d.tx_wr    = '0;
         s_d.tx_cnt   = '0;
         s_d.tx_flush = 1'b1;
      end else if (tx_pop) begin
         s_d.tx_rd  = s_q.tx_rd + 1'b1;
         s_d.tx_cnt = s_q.tx_cnt - 1'b1;
      end
      if (tx_push) begin
         s_d.tx_mem[s_d.tx_wr] = PWDATA[7:0];
         s_d.tx_wr             = s_d.tx_wr + 1'b1;
         s_d.tx_cnt            = s_d.tx_cnt + 1'b1;
      end
      s_d.tx_valid = (s_d.tx_cnt != '0);
      s_d.tx_data  = s_d.tx_mem[s_d.tx_rd];

      // 16x oversample tick; divisors of 0 and 1 give no rate, so no tick
      if (!s_q.ctrl[CT_ON] || (s_q.baud_divisor_value < 16'h0002)) begin
         s_d.bcnt = 16'h0000;
      end else if (bsum >= ({1'b0, s_q.baud_divisor_value} - 17'h00001)) begin
         s_d.bcnt = 16'h0000;
         s_d.tick = 1'b1;
      end else begin
         s_d.bcnt = bsum[15:0];
      end

      // mode parameters as seen by the protocol engines
      s_d.par1    = {s_d.p1[8] && ninth_used(s_d.ctrl[3:0]), s_d.p1[7:0]};
      s_d.par2    = {s_d.p2[8] && ninth_used(s_d.ctrl[3:0]), s_d.p2[7:0]};
      s_d.protected_identifier     = s_d.p1[5:0];
      s_d.lin_cnt = s_d.p2[7:0];
      s_d.achar   = {1'b1, s_d.p1[7:0]};
      if (RX_VALID) begin
         s_d.match = (s_q.ctrl[3:0] == MODE_ADDR) && (((RX_DATA ^ s_q.p2[7:0]) & s_q.mask) == 8'h00);
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         s_q       <= '0;
         s_q.transmit_data_port   <= RST_TXB;
         s_q.baud_divisor_value   <= RST_BRG;
         s_q.p1    <= RST_PARAM;
         s_q.p2    <= RST_PARAM;
         s_q.mask  <= RST_MASK;
         s_q.ctrl  <= RST_CTRL;
         s_q.achar <= {1'b1, RST_PARAM[7:0]};
      end else if (CE) begin
         s_q <= s_d;
      end
   end

   assign PRDATA       = s_q.prdata;
   assign PREADY       = s_q.pready;
   assign PSLVERR      = s_q.pslverr;
   assign TX_VALID     = s_q.tx_valid;
   assign TX_DATA      = s_q.tx_data;
   assign TX_FLUSH     = s_q.tx_flush;
   assign BAUD_TICK    = s_q.tick;
   assign PARAM_ONE    = s_q.par1;
   assign PARAM_TWO    = s_q.par2;
   assign LIN_PID      = s_q.protected_identifier;
   assign LIN_TX_COUNT = s_q.lin_cnt;
   assign ADDR_CHAR    = s_q.achar;
   assign ADDR_MATCH   = s_q.match;

   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   rx_flush_a: assert property (CE && rx_flush && !RX_VALID |=> s_q.rx_cnt == '0)
      else $error("receive flush left data");
   rx_hold_a: assert property (CE && wr && hit(PADDR, IDX_STAT) && !PWDATA[ST_RECEIVE_EMPTY_FLAG] && s_q.rx_cnt != '0
      |=> s_q.rx_cnt != '0) else $error("zero write emptied receive buffer");
   full_read_a: assert property (CE && setup && hit(PADDR, IDX_STAT) && s_q.rx_cnt == RX_FULL_CNT
      |=> PRDATA[ST_RECEIVE_FULL_FLAG] && !PRDATA[ST_RECEIVE_EMPTY_FLAG]) else $error("full flag wrong");
   tx_flush_a: assert property (CE && tx_flush |=> TX_FLUSH && !TX_VALID)
      else $error("transmit flush incomplete");
   baud_tick_a: assert property (CE && s_q.ctrl[CT_ON] && s_q.baud_divisor_value > 16'h0001
      && bsum >= {1'b0, s_q.baud_divisor_value} - 17'h00001 |=> BAUD_TICK && s_q.bcnt == 16'h0000)
      else $error("baud tick missing");
   brg_lock_a: assert property (CE && wr && s_q.ctrl[CT_ON]
      && (hit(PADDR, IDX_BRGL) || hit(PADDR, IDX_BRGH)) |=> $stable(s_q.baud_divisor_value)) else $error("divisor changed while on");
   rx_read_a: assert property (CE && setup && hit(PADDR, IDX_RXB) |=> PRDATA[7:0] == $past(rx_head))
      else $error("receive port not fifo head");
   tx_push_a: assert property (CE && tx_push && !tx_pop |=> TX_VALID && s_q.tx_cnt == $past(s_q.tx_cnt) + 1'b1)
      else $error("transmit byte not appended");
   rx_pop_a: assert property (CE && rx_pop && !RX_VALID |=> s_q.rx_cnt == $past(s_q.rx_cnt) - 1'b1)
      else $error("receive count not decremented");
   ninth_bit_a: assert property (!ninth_used(s_q.ctrl[3:0]) |-> !PARAM_ONE[8] && !PARAM_TWO[8])
      else $error("ninth parameter bit leaked");
   addr_char_a: assert property (ADDR_CHAR[8] && ADDR_CHAR[7:0] == s_q.p1[7:0] && LIN_PID == s_q.p1[5:0])
      else $error("address character ninth bit clear");
   addr_match_a: assert property (CE && RX_VALID && s_q.ctrl[3:0] == MODE_ADDR
      && ((RX_DATA ^ s_q.p2[7:0]) & s_q.mask) == 8'h00 |=> ADDR_MATCH) else $error("address match missed");
endmodule // uart_buffer_regs

// >>> pkg/uart_regs_pkg.sv
// register map, field positions and reset values of the uart buffer/parameter slice
// assumes a 32-bit apb bus; each register index sits at byte address index*4
package uart_regs_pkg;
   localparam int          APB_AW     = 14;
   localparam logic [11:0] IDX_RXB    = 12'h2A1;
   localparam logic [11:0] IDX_TXB    = 12'h2A3;
   localparam logic [11:0] IDX_P1L    = 12'h2A5;
   localparam logic [11:0] IDX_P1H    = 12'h2A6;
   localparam logic [11:0] IDX_P2L    = 12'h2A7;
   localparam logic [11:0] IDX_P2H    = 12'h2A8;
   localparam logic [11:0] IDX_MASK   = 12'h2A9;
   localparam logic [11:0] IDX_CTRL   = 12'h2AB;
   localparam logic [11:0] IDX_BRGL   = 12'h2AE;
   localparam logic [11:0] IDX_BRGH   = 12'h2AF;
   localparam logic [11:0] IDX_STAT   = 12'h2B0;
   // status field positions
   localparam int          ST_TRANSMIT_EMPTY_FLAG    = 5;
   localparam int          ST_TXBF    = 4;
   localparam int          ST_RECEIVE_EMPTY_FLAG    = 1;
   localparam int          ST_RECEIVE_FULL_FLAG    = 0;
   // control field positions
   localparam int          CT_BAUD_SPEED_SELECT    = 7;
   localparam int          CT_ON      = 6;
   // mode encodings held in control bits 3:0
   localparam logic [3:0]  MODE_ASYNC = 4'h0;
   localparam logic [3:0]  MODE_ADDR  = 4'h1;
   localparam logic [3:0]  MODE_LIN   = 4'hC;
   localparam logic [3:0]  MODE_DMX   = 4'hA;
   localparam logic [3:0]  MODE_DGEAR = 4'h8;
   localparam logic [3:0]  MODE_DDEV  = 4'h9;
   // reset values
   localparam logic [15:0] RST_BRG    = 16'h0000;
   localparam logic [7:0]  RST_TXB    = 8'h00;
   localparam logic [8:0]  RST_PARAM  = 9'h000;
   localparam logic [7:0]  RST_MASK   = 8'h00;
   localparam logic [7:0]  RST_CTRL   = 8'h00;
   // oversample counter step: normal and high-speed (four times faster)
   localparam logic [16:0] STEP_NORM  = 17'h00001;
   localparam logic [16:0] STEP_FAST  = 17'h00004;
endpackage

// >>> verification/serial_node_model.sv
// remote serial node: hands received bytes to the block and takes its transmit bytes
// assumes the block's clock; stall holds off the transmit handshake
module serial_node_model (
   input  wire logic  CLOCK,
   input  wire logic  RST_N,
   output logic       RX_VALID,
   output logic [7:0] RX_DATA,
   output logic       TX_READY
);
   timeunit 1ns;
   timeprecision 1ps;
   logic stall;
   initial begin
      RX_VALID = 1'b0;
      RX_DATA  = 8'hA5;
      TX_READY = 1'b0;
      stall    = 1'b1;
   end
   // toggling ready gives pops with gaps, a slow shifter
   always @(posedge CLOCK) TX_READY <= RST_N && !stall && !TX_READY;
   task automatic send_byte(input logic [7:0] b);
      @(posedge CLOCK);
      RX_VALID <= 1'b1;
      RX_DATA  <= b;
      @(posedge CLOCK);
      RX_VALID <= 1'b0;
      // line no longer valid: inverse, so a late sample is caught
      RX_DATA  <= ~b;
   endtask
endmodule // serial_node_model

// >>> verification/tb_top.sv
// self-checking bench for the uart buffer and parameter registers
// assumes the serial node model at the far side; this module is the apb master
module tb_top;
   import uart_regs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic              CLOCK, RST_N, CE, PSEL, PENABLE, PWRITE;
   logic [APB_AW-1:0] PADDR;
   logic [31:0]       PWDATA;
   wire logic [31:0]  PRDATA;
   wire logic         PREADY, PSLVERR, RX_VALID, TX_READY, TX_VALID, TX_FLUSH, BAUD_TICK, ADDR_MATCH;
   wire logic [7:0]   RX_DATA, TX_DATA, LIN_TX_COUNT;
   wire logic [8:0]   PARAM_ONE, PARAM_TWO, ADDR_CHAR;
   wire logic [5:0]   LIN_PID;
   logic [33:0]       exp_q[$];
   logic [7:0]        tx_q[$];
   logic [33:0]       note;
   logic [7:0]        b[3];
   logic [7:0]        p1, p2;
   logic              h;
   logic [3:0]        modes[6] = '{MODE_DMX, MODE_DDEV, MODE_DGEAR, MODE_LIN, MODE_ASYNC, MODE_ADDR};
   int                err_total, check_count, seed, flush_seen, tick_gap, gap_n, n;

   uart_buffer_regs uut (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .TX_READY(TX_READY),
      .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_FLUSH(TX_FLUSH), .BAUD_TICK(BAUD_TICK),
      .PARAM_ONE(PARAM_ONE), .PARAM_TWO(PARAM_TWO), .LIN_PID(LIN_PID), .LIN_TX_COUNT(LIN_TX_COUNT),
      .ADDR_CHAR(ADDR_CHAR), .ADDR_MATCH(ADDR_MATCH));
   serial_node_model node (.CLOCK(CLOCK), .RST_N(RST_N), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
      .TX_READY(TX_READY));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // one transfer; d is write data or expected read data, the note carries {care, err, data}
   task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d, input logic c, input logic e);
      @(posedge CLOCK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= w;
      PADDR   <= {idx, 2'b00};
      PWDATA  <= {24'h0, d};
      exp_q.push_back({c, e, 24'h0, d});
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      // access phase holds until pready is sampled high at a rising edge; release right after it
      do
         @(posedge CLOCK);
      while (PREADY !== 1'b1);
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 1'b0, 1'b0);
   endtask
   task automatic rd(input logic [11:0] idx, input logic [7:0] e);
      apb(1'b0, idx, e, 1'b1, 1'b0);
   endtask

   always @(posedge CLOCK) begin
      if (PSEL && PENABLE && PREADY) begin
         note = exp_q.pop_front();
         chk("slave error", {31'h0, note[32]}, {31'h0, PSLVERR});
         if (note[33]) chk("read data", {24'h0, note[7:0]}, PRDATA);
      end
      if (TX_VALID && TX_READY) chk("tx byte", {24'h0, tx_q.pop_front()}, {24'h0, TX_DATA});
      if (TX_FLUSH) flush_seen++;
      if (BAUD_TICK) begin
         tick_gap = gap_n;
         gap_n = 1;
      end else
         gap_n++;
   end

   initial begin
      CLOCK = 1'b0;
      forever #25 CLOCK = ~CLOCK;
   end
   initial begin
      #3000000;
      err_total++;
      wrap_up();
   end

   initial begin
      seed = 86628;
      {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
      CE = 1'b1;
      repeat (2) @(posedge CLOCK);
      RST_N <= 1'b1;
      rd(IDX_STAT, 8'h22);
      rd(IDX_BRGH, 8'h00);
      rd(IDX_TXB, RST_TXB);
      rd(IDX_P2L, 8'h00);
      apb(1'b0, 12'h2A0, 8'h00, 1'b0, 1'b1);
      for (int i = 0; i < 3; i++) begin
         b[i] = 8'($random(seed));
         node.send_byte(b[i]);
      end
      rd(IDX_STAT, 8'h21);
      wr(IDX_STAT, 8'h00);
      rd(IDX_STAT, 8'h21);
      rd(IDX_RXB, b[0]);
      rd(IDX_STAT, 8'h20);
      rd(IDX_RXB, b[1]);
      rd(IDX_STAT, 8'h22);
      node.send_byte(b[2]);
      wr(IDX_STAT, 8'h02);
      rd(IDX_STAT, 8'h22);
      for (int i = 0; i < 3; i++) begin
         b[i] = 8'($random(seed));
         wr(IDX_TXB, b[i]);
         if (i < 2) tx_q.push_back(b[i]);
      end
      rd(IDX_STAT, 8'h12);
      wr(IDX_STAT, 8'h00);
      rd(IDX_STAT, 8'h12);
      node.stall <= 1'b0;
      n = 0;
      while (tx_q.size() > 0 && n < 40) begin
         @(posedge CLOCK);
         n++;
      end
      node.stall <= 1'b1;
      chk("tx bytes left", 0, tx_q.size());
      rd(IDX_STAT, 8'h22);
      wr(IDX_TXB, b[0]);
      wr(IDX_STAT, 8'h20);
      rd(IDX_STAT, 8'h22);
      chk("flush pulses", 1, flush_seen);
      wr(IDX_BRGL, 8'h09);
      wr(IDX_CTRL, 8'h40);
      wr(IDX_BRGL, 8'h03);
      rd(IDX_BRGL, 8'h09);
      repeat (30) @(negedge CLOCK);
      chk("normal tick gap", 8, tick_gap);
      wr(IDX_CTRL, 8'hC0);
      repeat (30) @(negedge CLOCK);
      chk("fast tick gap", 2, tick_gap);
      foreach (modes[m]) begin
         p1 = 8'($random(seed));
         p2 = 8'($random(seed));
         wr(IDX_CTRL, {4'h0, modes[m]});
         wr(IDX_P1H, 8'h01);
         wr(IDX_P1L, p1);
         wr(IDX_P2H, 8'h01);
         wr(IDX_P2L, p2);
         h = modes[m] == MODE_DMX || modes[m][3:1] == 3'b100;
         @(negedge CLOCK);
         chk("param one", {23'h0, h, p1}, {23'h0, PARAM_ONE});
         chk("param two", {23'h0, h, p2}, {23'h0, PARAM_TWO});
         chk("lin id", {26'h0, p1[5:0]}, {26'h0, LIN_PID});
         chk("lin count", {24'h0, p2}, {24'h0, LIN_TX_COUNT});
         chk("address char", {23'h0, 1'b1, p1}, {23'h0, ADDR_CHAR});
      end
      wr(IDX_MASK, 8'hF0);
      node.send_byte(p2 ^ 8'h0F);
      @(negedge CLOCK);
      chk("address match", 1, {31'h0, ADDR_MATCH});
      node.send_byte(p2 ^ 8'h10);
      @(negedge CLOCK);
      chk("address miss", 0, {31'h0, ADDR_MATCH});
      wrap_up();
   end
endmodule // tb_top
